//--- core/reset_state_pkg.sv
/*
  Package for the register reset-state block: register offsets,
  reset values, widths and the packed bus carriers.
  Assumes an AXI4-Lite register bus with 32-bit data, one clock.
*/
package reset_state_pkg;

  ////////////////////////////////////////////////////////////////
  // Register byte offsets (AXI4-Lite, one aligned word each)
  localparam logic [7:0] OFF_PC = 8'h00;
  localparam logic [7:0] OFF_INTERRUPT_ENABLE_ZERO = 8'h04;
  localparam logic [7:0] OFF_LOOP_BEGIN_ZERO = 8'h08;
  localparam logic [7:0] OFF_LOOP_END_ZERO = 8'h0c;
  localparam logic [7:0] OFF_VBASE = 8'h10;
  localparam logic [7:0] OFF_CLOOP = 8'h14;
  localparam logic [7:0] OFF_CSTATE = 8'h18;
  localparam logic [7:0] OFF_INS = 8'h1c;
  localparam logic [7:0] OFF_IOC = 8'h20;
  localparam logic [7:0] OFF_MWAIT = 8'h24;
  localparam logic [7:0] OFF_PIN_STATUS = 8'h28;
  localparam logic [7:0] OFF_TEST_DATA = 8'h2c;
  localparam logic [7:0] OFF_SCRATCH = 8'h30;
  localparam logic [7:0] OFF_BOOT_CTRL = 8'h34;

  ////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [19:0] PC_INTERNAL_BOOT_ROM = 20'h20000;
  localparam logic [19:0] PC_EXTERNAL_ROM_REGION = 20'h80000;
  localparam logic [19:0] CORE20_RESET = 20'h00000;
  localparam logic [19:0] VBASE_RESET = 20'h20014;
  localparam logic [15:0] CORE16_RESET = 16'h0000;
  localparam logic [15:0] IOC_RESET = 16'h0000;
  localparam logic [15:0] MWAIT_RESET = 16'h0fff;

  ////////////////////////////////////////////////////////////////
  // Field positions
  localparam int BOOT_EXIT_BIT = 0;
  localparam int PIN_WIDTH = 8;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  ////////////////////////////////////////////////////////////////
  // Bus carriers
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } wr_req_t;

  typedef struct packed {
    logic [31:0] data;
    logic [1:0] resp;
  } rd_rsp_t;

endpackage

//--- core/axil_slave_if_ctl.sv
/*
  AXI4-Lite slave handshake: holds one write and one read at a time,
  takes address and data in either order, presents a write request
  pulse and a read request pulse to the register file.
  Assumes a single clock aclk and synchronous active-low aresetn.
*/
`timescale 1ns/1ps
module axil_slave_if_ctl (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write address and data
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // Read address and data
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Register file side
  output logic wr_go,
  output reset_state_pkg::wr_req_t wr_req,
  input wire logic wr_ok,
  output logic rd_go,
  output logic [7:0] rd_addr,
  input wire reset_state_pkg::rd_rsp_t rd_rsp
);

  logic aw_held_reg;
  logic w_held_reg;

  ////////////////////////////////////////////////////////////////
  // Write channel capture
  assign awready = !aw_held_reg && !bvalid;
  assign wready = !w_held_reg && !bvalid;
  assign wr_go = aw_held_reg && w_held_reg && !bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      wr_req <= '0;
    end else if (wr_go) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_held_reg <= 1'b1;
        wr_req.addr <= awaddr;
      end
      if (wvalid && wready) begin
        w_held_reg <= 1'b1;
        wr_req.data <= wdata;
        wr_req.strb <= wstrb;
      end
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= reset_state_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid <= 1'b1;
      bresp <= wr_ok ? reset_state_pkg::RESP_OKAY : reset_state_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Read channel
  assign arready = !rvalid;
  assign rd_go = arvalid && arready;
  assign rd_addr = araddr;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= reset_state_pkg::RESP_OKAY;
    end else if (rd_go) begin
      rvalid <= 1'b1;
      rdata <= rd_rsp.data;
      rresp <= rd_rsp.resp;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule

//--- core/reset_state_regs.sv
/*
  Register bank with documented reset states for core and peripheral
  registers, boot-source dependent start address and boot-exit handling.
  Assumes one clock aclk at 125 MHz, synchronous active-low aresetn
  used as the pin reset, and an AXI4-Lite master for software access.
*/
// Notes on behaviour
// (R1) Holding the active-low reset low puts every defined register into its reset state.
// (R2) Bits with no defined reset value are never touched by reset and keep their content.
// (R3) The pin status register shows the eight I/O pins in its low byte and zero above.
// (R4) With the boot select low at reset the start address is the internal boot ROM base.
// (R5) With the boot select high at reset the start address is the external ROM base.
// (R6) Boot exit leaves interrupt enable, loop begin, loop end, vector base, count, cache.
// (R7) Boot exit returns only the I/O configuration register to its reset value.
// (R8) Software should disable interrupts and write all ones to the pending register.
// (R9) The wait-state register always resets to 0x0fff whatever the pin levels.
// (R10) The test-port data word is the only 32-bit peripheral register.
// (R11) Reset values hold while reset is low and until the first edge after release.
`timescale 1ns/1ps
module reset_state_regs (
  // Clock and pin reset
  input wire logic aclk,
  input wire logic aresetn,
  // Device pins
  input wire logic boot_source_select,
  input wire logic [7:0] general_io_pins,
  // Register state toward the core
  output logic [19:0] program_counter,
  output logic [15:0] io_config,
  output logic [15:0] wait_states,
  output logic boot_exit_pulse,
  // AXI4-Lite write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);

  logic wr_go;
  logic wr_ok;
  logic rd_go;
  logic [7:0] rd_addr;
  reset_state_pkg::wr_req_t wr_req;
  reset_state_pkg::rd_rsp_t rd_rsp;

  logic [19:0] pc_reg;
  logic [19:0] interrupt_enable_zero_reg;
  logic [19:0] loop_begin_zero_reg;
  logic [19:0] loop_end_zero_reg;
  logic [19:0] vbase_reg;
  logic [15:0] cloop_reg;
  logic [15:0] cstate_reg;
  logic [19:0] ins_reg;
  logic [15:0] ioc_reg;
  logic [15:0] mwait_reg;
  logic [31:0] test_data_reg;
  logic [15:0] scratch_reg;
  logic [31:0] wmask;

  ////////////////////////////////////////////////////////////////
  // Bus slave
  axil_slave_if_ctl axil_slave_if_ctl_inst (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .wr_go(wr_go),
    .wr_req(wr_req),
    .wr_ok(wr_ok),
    .rd_go(rd_go),
    .rd_addr(rd_addr),
    .rd_rsp(rd_rsp)
  );

  // Byte-lane mask from strobes
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{wr_req.strb[i]}};
    end
  end

  // Write helpers
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [31:0] m);
    merge = (old_v & ~m) | (new_v & m);
  endfunction

  function automatic logic hit(input logic [7:0] off);
    hit = wr_go && (wr_req.addr == off);
  endfunction

  // Spelled out so the pulse follows wr_go; a function call hides it from the assign
  assign boot_exit_pulse = wr_go && (wr_req.addr == reset_state_pkg::OFF_BOOT_CTRL) &&
                           wr_req.strb[0] && wr_req.data[reset_state_pkg::BOOT_EXIT_BIT];

  ////////////////////////////////////////////////////////////////
  // Start address from boot source
  always_ff @(posedge aclk) begin
    // (R4) Internal ROM start
    // (R5) External ROM start
    if (!aresetn) begin
      pc_reg <= boot_source_select ? reset_state_pkg::PC_EXTERNAL_ROM_REGION
                                   : reset_state_pkg::PC_INTERNAL_BOOT_ROM;
    end else if (hit(reset_state_pkg::OFF_PC)) begin
      pc_reg <= 20'(merge(32'(pc_reg), wr_req.data, wmask));
    end
  end

  ////////////////////////////////////////////////////////////////
  // Core registers with defined resets
  always_ff @(posedge aclk) begin
    // (R1) Pin reset values
    // (R11) Held through reset
    if (!aresetn) begin
      interrupt_enable_zero_reg <= reset_state_pkg::CORE20_RESET;
      loop_begin_zero_reg <= reset_state_pkg::CORE20_RESET;
      loop_end_zero_reg <= reset_state_pkg::CORE20_RESET;
      vbase_reg <= reset_state_pkg::VBASE_RESET;
      cloop_reg <= reset_state_pkg::CORE16_RESET;
      cstate_reg <= reset_state_pkg::CORE16_RESET;
      ins_reg <= reset_state_pkg::CORE20_RESET;
    end else begin
      // (R6) Kept over boot exit
      if (hit(reset_state_pkg::OFF_INTERRUPT_ENABLE_ZERO)) begin
        interrupt_enable_zero_reg <= 20'(merge(32'(interrupt_enable_zero_reg), wr_req.data,
                                               wmask));
      end
      if (hit(reset_state_pkg::OFF_LOOP_BEGIN_ZERO)) begin
        loop_begin_zero_reg <= 20'(merge(32'(loop_begin_zero_reg), wr_req.data, wmask));
      end
      if (hit(reset_state_pkg::OFF_LOOP_END_ZERO)) begin
        loop_end_zero_reg <= 20'(merge(32'(loop_end_zero_reg), wr_req.data, wmask));
      end
      if (hit(reset_state_pkg::OFF_VBASE)) begin
        vbase_reg <= 20'(merge(32'(vbase_reg), wr_req.data, wmask));
      end
      if (hit(reset_state_pkg::OFF_CLOOP)) begin
        cloop_reg <= 16'(merge(32'(cloop_reg), wr_req.data, wmask));
      end
      if (hit(reset_state_pkg::OFF_CSTATE)) begin
        cstate_reg <= 16'(merge(32'(cstate_reg), wr_req.data, wmask));
      end
      // (R8) Ones clear pending
      if (hit(reset_state_pkg::OFF_INS)) begin
        ins_reg <= ins_reg & ~20'(wr_req.data & wmask);
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Peripheral registers
  always_ff @(posedge aclk) begin
    // (R9) Fixed wait states
    if (!aresetn) begin
      ioc_reg <= reset_state_pkg::IOC_RESET;
      mwait_reg <= reset_state_pkg::MWAIT_RESET;
    end else begin
      // (R7) Only ioc reinitialised
      if (boot_exit_pulse) begin
        ioc_reg <= reset_state_pkg::IOC_RESET;
      end else if (hit(reset_state_pkg::OFF_IOC)) begin
        ioc_reg <= 16'(merge(32'(ioc_reg), wr_req.data, wmask));
      end
      if (hit(reset_state_pkg::OFF_MWAIT)) begin
        mwait_reg <= 16'(merge(32'(mwait_reg), wr_req.data, wmask));
      end
    end
  end

  // (R2) No reset on undefined bits
  // (R10) Only 32-bit peripheral
  always_ff @(posedge aclk) begin
    if (hit(reset_state_pkg::OFF_TEST_DATA)) begin
      test_data_reg <= merge(test_data_reg, wr_req.data, wmask);
    end
    if (hit(reset_state_pkg::OFF_SCRATCH)) begin
      scratch_reg <= 16'(merge(32'(scratch_reg), wr_req.data, wmask));
    end
  end

  ////////////////////////////////////////////////////////////////
  // Write decode acceptance
  always_comb begin
    wr_ok = 1'b1;
    if (wr_req.addr == reset_state_pkg::OFF_PIN_STATUS) begin
      wr_ok = 1'b1;
    end else if (wr_req.addr > reset_state_pkg::OFF_BOOT_CTRL || wr_req.addr[1:0] != 2'b00) begin
      wr_ok = 1'b0;
    end
  end

  // Read decode
  always_comb begin
    rd_rsp.resp = reset_state_pkg::RESP_OKAY;
    rd_rsp.data = 32'h0000_0000;
    if (rd_addr == reset_state_pkg::OFF_PC) begin
      rd_rsp.data = 32'(pc_reg);
    end else if (rd_addr == reset_state_pkg::OFF_INTERRUPT_ENABLE_ZERO) begin
      rd_rsp.data = 32'(interrupt_enable_zero_reg);
    end else if (rd_addr == reset_state_pkg::OFF_LOOP_BEGIN_ZERO) begin
      rd_rsp.data = 32'(loop_begin_zero_reg);
    end else if (rd_addr == reset_state_pkg::OFF_LOOP_END_ZERO) begin
      rd_rsp.data = 32'(loop_end_zero_reg);
    end else if (rd_addr == reset_state_pkg::OFF_VBASE) begin
      rd_rsp.data = 32'(vbase_reg);
    end else if (rd_addr == reset_state_pkg::OFF_CLOOP) begin
      rd_rsp.data = 32'(cloop_reg);
    end else if (rd_addr == reset_state_pkg::OFF_CSTATE) begin
      rd_rsp.data = 32'(cstate_reg);
    end else if (rd_addr == reset_state_pkg::OFF_INS) begin
      rd_rsp.data = 32'(ins_reg);
    end else if (rd_addr == reset_state_pkg::OFF_IOC) begin
      rd_rsp.data = 32'(ioc_reg);
    end else if (rd_addr == reset_state_pkg::OFF_MWAIT) begin
      rd_rsp.data = 32'(mwait_reg);
    end else if (rd_addr == reset_state_pkg::OFF_PIN_STATUS) begin
      // (R3) Pins in low byte
      rd_rsp.data = {24'h000000, general_io_pins};
    end else if (rd_addr == reset_state_pkg::OFF_TEST_DATA) begin
      rd_rsp.data = test_data_reg;
    end else if (rd_addr == reset_state_pkg::OFF_SCRATCH) begin
      rd_rsp.data = 32'(scratch_reg);
    end else if (rd_addr == reset_state_pkg::OFF_BOOT_CTRL) begin
      rd_rsp.data = 32'h0000_0000;
    end else begin
      rd_rsp.resp = reset_state_pkg::RESP_SLVERR;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Outputs
  assign program_counter = pc_reg;
  assign io_config = ioc_reg;
  assign wait_states = mwait_reg;

endmodule

//--- verification/reset_state_regs_properties.sv
/*
  Checker for reset_state_regs: reset values, boot exit and bus answers.
  Assumes one clock aclk and synchronous active-low aresetn; bound below.
*/
`timescale 1ns/1ps
module reset_state_checker (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Pins and register state
  input wire logic boot_source_select,
  input wire logic [7:0] general_io_pins,
  input wire logic [19:0] program_counter,
  input wire logic [15:0] io_config,
  input wire logic [15:0] wait_states,
  input wire logic boot_exit_pulse,
  // Bus signals
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid
);
  ////////////////////////////////////////////////////////////////
  // One domain for every property
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Values seen at the first edge after release
  a_pc_internal: assert property ($rose(aresetn) && !$past(boot_source_select) |->
    program_counter == reset_state_pkg::PC_INTERNAL_BOOT_ROM) else $error("bad start address");
  a_pc_external: assert property ($rose(aresetn) && $past(boot_source_select) |->
    program_counter == reset_state_pkg::PC_EXTERNAL_ROM_REGION) else $error("bad start address");
  a_wait_fixed: assert property ($rose(aresetn) |->
    wait_states == reset_state_pkg::MWAIT_RESET) else $error("wait states not fixed value");
  a_reset_clears: assert property ($rose(aresetn) |->
    io_config == reset_state_pkg::IOC_RESET && !bvalid && !rvalid) else $error("reset state");

  // Boot exit effects
  a_exit_clears_ioc: assert property (boot_exit_pulse |=>
    io_config == reset_state_pkg::IOC_RESET) else $error("io config kept on exit");
  a_exit_keeps_rest: assert property (boot_exit_pulse |=>
    $stable(wait_states) && $stable(program_counter)) else $error("register changed on exit");

  // Read data and bus answers
  a_pin_status_read: assert property (arvalid && arready &&
    araddr == reset_state_pkg::OFF_PIN_STATUS |=> rdata == {24'h0, $past(general_io_pins)})
    else $error("pin status read wrong");
  a_read_unmapped: assert property (arvalid && arready &&
    araddr > reset_state_pkg::OFF_BOOT_CTRL |=>
    rresp == reset_state_pkg::RESP_SLVERR && rdata == 32'h0) else $error("unmapped read");
  a_read_answer: assert property (arvalid && arready |=> rvalid) else $error("no read answer");
  a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
    else $error("no write answer");
  a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped");

  // Main scenarios reached
  c_exit: cover property (boot_exit_pulse);
  c_boot_high: cover property ($rose(aresetn) && $past(boot_source_select));
  c_slverr: cover property (rvalid && rresp == reset_state_pkg::RESP_SLVERR);
endmodule

bind reset_state_regs reset_state_checker chk_inst (
  .aclk, .aresetn, .boot_source_select, .general_io_pins, .program_counter, .io_config,
  .wait_states, .boot_exit_pulse, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready,
  .bresp, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid
);

//--- verification/testbench.sv
/*
  Self-checking bench for reset_state_regs: reset values per boot select,
  pin status, boot exit, kept bits across reset and unmapped access.
  Assumes the checker is bound from its own file.
*/
`timescale 1ns/1ps
module testbench;
  logic aclk, aresetn, boot_source_select, boot_exit_pulse;
  logic [7:0] general_io_pins, awaddr, araddr;
  logic [19:0] program_counter;
  logic [15:0] io_config, wait_states;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  int fail_count = 0;
  int checked = 0;

  reset_state_regs reset_state_regs_inst (
    .aclk, .aresetn, .boot_source_select, .general_io_pins, .program_counter, .io_config,
    .wait_states, .boot_exit_pulse, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready
  );

  // 125 MHz clock
  initial aclk = 1'b0;
  always #4 aclk = ~aclk;

  ////////////////////////////////////////////////////////////////
  // Verdict and comparison
  task automatic end_sim();
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////
  // Bus master, bounded waits
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    repeat (64) begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
      if (n > 40) begin
        fail_count++;
        end_sim();
      end
    end
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    repeat (64) begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
      if (n > 40) begin
        fail_count++;
        end_sim();
      end
    end
  endtask

  // Access with an OKAY answer expected
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_write(a, d, r);
    check(32'(r), 32'(reset_state_pkg::RESP_OKAY));
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    check(d, exp);
    check(32'(r), 32'(reset_state_pkg::RESP_OKAY));
  endtask

  task automatic do_reset(input logic sel);
    @(posedge aclk);
    aresetn <= 1'b0;
    boot_source_select <= sel;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  ////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset_values(input logic sel);
    logic [31:0] pc;
    logic [31:0] exp;
    pc = sel ? 32'(reset_state_pkg::PC_EXTERNAL_ROM_REGION)
             : 32'(reset_state_pkg::PC_INTERNAL_BOOT_ROM);
    do_reset(sel);
    #1;
    check(32'(program_counter), pc);
    rd_chk(reset_state_pkg::OFF_PC, pc);
    for (int i = 1; i < 10; i++) begin
      exp = (i == 4) ? 32'(reset_state_pkg::VBASE_RESET) : 32'h0;
      if (i == 9) exp = 32'(reset_state_pkg::MWAIT_RESET);
      rd_chk(8'(4 * i), exp);
    end
  endtask

  task automatic t_pins();
    logic [7:0] pats [4] = '{8'h00, 8'ha5, 8'h5a, 8'hff};
    for (int k = 0; k < 4; k++) begin
      @(posedge aclk);
      general_io_pins <= pats[k];
      rd_chk(reset_state_pkg::OFF_PIN_STATUS, {24'h0, pats[k]});
    end
    wr(reset_state_pkg::OFF_PIN_STATUS, 32'h0);
    rd_chk(reset_state_pkg::OFF_PIN_STATUS, 32'h0000_00ff);
  endtask

  task automatic t_boot_exit();
    for (int i = 1; i < 10; i++) begin
      if (i != 7) wr(8'(4 * i), 32'h1000 + i);
    end
    wr(reset_state_pkg::OFF_BOOT_CTRL, 32'h1);
    #1;
    check(32'(io_config), 32'h0);
    for (int i = 1; i < 10; i++) begin
      rd_chk(8'(4 * i), (i == 7 || i == 8) ? 32'h0 : 32'h1000 + i);
    end
    wr(reset_state_pkg::OFF_INS, 32'h000f_ffff);
    rd_chk(reset_state_pkg::OFF_INS, 32'h0);
  endtask

  task automatic t_kept();
    wr(reset_state_pkg::OFF_TEST_DATA, 32'hdead_beef);
    wr(reset_state_pkg::OFF_SCRATCH, 32'h1234_abcd);
    t_reset_values(1'b1);
    rd_chk(reset_state_pkg::OFF_TEST_DATA, 32'hdead_beef);
    rd_chk(reset_state_pkg::OFF_SCRATCH, 32'h0000_abcd);
    // Byte-lane write keeps the upper lanes of the 32-bit word
    wstrb <= 4'h1;
    wr(reset_state_pkg::OFF_TEST_DATA, 32'h0000_0011);
    wstrb <= 4'hf;
    rd_chk(reset_state_pkg::OFF_TEST_DATA, 32'hdead_be11);
  endtask

  task automatic t_unmapped();
    logic [31:0] d;
    logic [1:0] r;
    axi_write(8'h40, 32'hffff_ffff, r);
    check(32'(r), 32'(reset_state_pkg::RESP_SLVERR));
    axi_read(8'h40, d, r);
    check(d, 32'h0);
    check(32'(r), 32'(reset_state_pkg::RESP_SLVERR));
  endtask

  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    aresetn = 1'b0;
    boot_source_select = 1'b0;
    general_io_pins = 8'h00;
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h0;
    wstrb = 4'hf;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
    t_reset_values(1'b0);
    t_pins();
    t_boot_exit();
    t_kept();
    t_unmapped();
    end_sim();
  end
endmodule
